// ### include/rci_pkg.sv
// Package for the remote command interpreter: register map, fields, codes, timing.
// Assumes a 25 MHz system clock and a host that sends parsed commands over the command port.
package rci_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int BAUD_DEFAULT = 19200;
  localparam int BAUD_DIV_DEFAULT = (CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT;
  localparam logic [4:0] GPIB_ADDR_MAX = 5'h1E;
  localparam logic [4:0] GPIB_ADDR_RESET = 5'h10;
  // Peak limit in millivolts, open circuit
  localparam int PEAK_LIMIT_MV = 10400;
  localparam logic [15:0] PEAK_LIMIT = 16'(PEAK_LIMIT_MV);
  localparam logic [15:0] AMP_RESET = 16'h0000;
  localparam logic [15:0] OFFS_RESET = 16'h0000;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam int WAVE_COUNT = 100;
  localparam int SEQ_COUNT = 10;
  localparam int STEP_COUNT = 16;
  // Register offsets
  localparam logic [7:0] REG_GPIB = 8'h00;
  localparam logic [7:0] REG_BAUD = 8'h04;
  localparam logic [7:0] REG_SERIAL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_MASK = 8'h10;
  localparam logic [7:0] REG_AMP = 8'h14;
  localparam logic [7:0] REG_OFFS = 8'h18;
  localparam logic [7:0] REG_FUNCTION_SELECT = 8'h1C;
  localparam logic [7:0] REG_ERRCODE = 8'h20;
  // Status bit positions
  localparam int ST_CMD_DONE = 0;
  localparam int ST_REJECT = 1;
  localparam int ST_BAD_SYNTAX = 2;
  localparam int ST_DELETE = 3;
  localparam int ST_WIDTH = 4;
  // Serial framing field positions
  localparam int SER_PARITY_BIT = 4;
  localparam int SER_HWFLOW_BIT = 5;

  typedef enum logic [3:0] {
    OP_AMPLITUDE_SET,
    OP_OFFSET_SET,
    OP_FUNCTION_SELECT,
    OP_STD_WAVE_DEFINE,
    OP_WAVE_SIZE,
    OP_SEQ_DEFINE,
    OP_SEQUENCE_STEP_ADD,
    OP_GPIB_ADDR,
    OP_BAUD
  } rci_op_t;

  typedef enum logic [1:0] {
    FT_STANDARD_WAVE_TYPE,
    FT_USER_WAVE,
    FT_SEQUENCE
  } rci_ftype_t;

  typedef enum logic [2:0] {
    ERR_NONE,
    ERR_PEAK,
    ERR_SPACE,
    ERR_RANGE
  } rci_err_t;

  typedef struct packed {
    rci_op_t op;
    logic has_space;
    logic has_data;
    logic [15:0] arg0;
    logic [15:0] arg1;
    logic [15:0] arg2;
    logic [15:0] arg3;
  } rci_cmd_t;

  typedef struct packed {
    rci_ftype_t ftype;
    logic [6:0] number;
    logic [3:0] std_shape;
  } rci_function_select_t;
endpackage

// ### design/rci_peak_check.sv
// Peak limit check on a candidate amplitude and offset pair.
// Assumes millivolt units, amplitude peak to peak unsigned, offset signed.
`timescale 1ns/1ns
module rci_peak_check
  import rci_pkg::*;
(
  input wire logic [15:0] amp_i,  // Peak to peak amplitude
  input wire logic signed [15:0] offs_i,  // Signed offset
  output logic ok_o  // Pair within limit
);
  logic [16:0] abs_offs;
  logic [17:0] total;

  always_comb
  begin
    abs_offs = offs_i[15] ? 17'(-offs_i) : 17'(offs_i);
    total = 18'(abs_offs) + 18'(amp_i[15:1]);
    ok_o = total < 18'(PEAK_LIMIT);
  end
endmodule

// ### design/rci_store.sv
// Waveform and sequence bookkeeping: presence of waveforms, sequence steps.
// Assumes one operation per cycle from the interpreter, same clock.
`timescale 1ns/1ns
module rci_store
  import rci_pkg::*;
(
  input wire logic clk_i,  // System clock
  input wire logic reset_i,  // Async reset
  input wire logic size_we_i,  // Waveform size write
  input wire logic [6:0] wave_i,  // Waveform number
  input wire logic [15:0] size_i,  // Waveform size
  input wire logic seq_del_i,  // Delete whole sequence
  input wire logic step_we_i,  // Sequence step write
  input wire logic [3:0] seq_i,  // Sequence number
  input wire logic [3:0] step_i,  // Step number
  input wire logic [15:0] repeat_i,  // Repeat count
  output logic deleted_o,  // Something was removed
  output logic [WAVE_COUNT-1:0] wave_present_o  // Waveform exists
);
  logic [STEP_COUNT-1:0] step_used [SEQ_COUNT];

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      wave_present_o <= '0;
    else if (size_we_i && wave_i < 7'(WAVE_COUNT))
      wave_present_o[wave_i] <= (size_i != 16'h0000);
  end

  genvar g;
  generate
    for (g = 0; g < SEQ_COUNT; g++)
    begin : g_seq
      always_ff @(posedge clk_i or posedge reset_i)
      begin
        if (reset_i)
          step_used[g] <= '0;
        else if (seq_del_i && seq_i == 4'(g))
          step_used[g] <= '0;
        else if (step_we_i && seq_i == 4'(g))
          step_used[g][step_i] <= (repeat_i != 16'h0000);
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      deleted_o <= 1'b0;
    else
      // Flag only removals of items that existed
      deleted_o <= (size_we_i && size_i == 16'h0000 && wave_i < 7'(WAVE_COUNT)
        && wave_present_o[wave_i])
        || (seq_del_i && seq_i < 4'(SEQ_COUNT) && |step_used[seq_i])
        || (step_we_i && repeat_i == 16'h0000 && seq_i < 4'(SEQ_COUNT)
        && step_used[seq_i][step_i]);
  end
endmodule

// ### design/rci_top.sv
// Remote command interpreter: link settings, immediate execution, peak check.
// Assumes a front end that delivers parsed commands one per strobe, same clock.
// Notes on behaviour
// - GPIB address accepts 0..30; listen only when addressed at it.
// - Serial resets to 19200 baud, eight data bits, no parity, hardware flow.
// - Only baud rate is writable; framing stays fixed.
// - Each command takes effect the cycle after it arrives.
// - Reject amplitude or offset if |offset|+amplitude/2 reaches 10.4 V.
// - Function select picks standard, user wave or sequence, plus number.
// - Standard type outputs last defined built-in shape.
// - Commands without header space are refused.
// - Waveform size zero removes the waveform.
// - Sequence define without step data deletes the sequence.
// - Step add with repeat zero deletes the step.
`timescale 1ns/1ns
module rci_top
  import rci_pkg::*;
(
  input wire logic CLK_I,  // 25 MHz clock
  input wire logic RESET_I,  // Async reset, high
  input wire logic [7:0] ADDR_I,  // Register address
  input wire logic [31:0] WDATA_I,  // Register write data
  input wire logic WR_I,  // Register write strobe
  input wire logic RD_I,  // Register read strobe
  output logic [31:0] RDATA_O,  // Register read data
  input wire logic CMD_VALID_I,  // Parsed command strobe
  input wire rci_pkg::rci_cmd_t CMD_I,  // Parsed command
  input wire logic [4:0] BUS_ADDR_I,  // Address on instrument bus
  input wire logic BUS_CMD_I,  // Command arrived via instrument bus
  output logic LISTEN_O,  // Addressed on instrument bus
  output logic [15:0] BAUD_DIV_O,  // Serial baud divider
  output logic [3:0] DATA_BITS_O,  // Serial data bits
  output logic PARITY_EN_O,  // Serial parity enable
  output logic HW_FLOW_O,  // Hardware flow control
  output logic [15:0] AMP_O,  // Active amplitude, mV
  output logic [15:0] OFFS_O,  // Active offset, mV signed
  output rci_pkg::rci_function_select_t FUNCTION_SELECT_O,  // Active function
  output logic [WAVE_COUNT-1:0] WAVE_PRESENT_O,  // Waveform exists
  output logic IRQ_O  // Interrupt, level
);
  logic [4:0] gpib_addr;
  logic [15:0] baud_div;
  logic [ST_WIDTH-1:0] status;
  logic [ST_WIDTH-1:0] mask;
  logic [15:0] amp;
  logic [15:0] offs;
  rci_function_select_t function_select;
  rci_err_t err_code;
  logic [3:0] std_shape;
  logic [15:0] cand_amp;
  logic [15:0] cand_offs;
  logic peak_ok;
  logic accept;
  logic reject;
  logic bad_syntax;
  logic deleted;
  logic [ST_WIDTH-1:0] events;

  // Bus commands only count when addressed to us
  assign accept = CMD_VALID_I && (!BUS_CMD_I || BUS_ADDR_I == gpib_addr);
  assign LISTEN_O = BUS_ADDR_I == gpib_addr;

  // Candidate settings for the peak check
  always_comb
  begin
    cand_amp = amp;
    cand_offs = offs;
    if (CMD_I.op == OP_AMPLITUDE_SET)
      cand_amp = CMD_I.arg0;
    if (CMD_I.op == OP_OFFSET_SET)
      cand_offs = CMD_I.arg0;
  end

  rci_peak_check u_peak
  (
    .amp_i(cand_amp),
    .offs_i(cand_offs),
    .ok_o(peak_ok)
  );

  always_comb
  begin
    bad_syntax = accept && !CMD_I.has_space;
    reject = 1'b0;
    if (accept && CMD_I.has_space)
    begin
      unique case (CMD_I.op)
        OP_AMPLITUDE_SET, OP_OFFSET_SET: reject = !peak_ok;
        OP_GPIB_ADDR: reject = CMD_I.arg0 > 16'(GPIB_ADDR_MAX);
        OP_BAUD: reject = CMD_I.arg0 == 16'h0000;
        OP_FUNCTION_SELECT: reject = CMD_I.arg0[1:0] == 2'b11
          || CMD_I.arg1 >= 16'(WAVE_COUNT);
        default: reject = 1'b0;
      endcase
    end
  end

  wire exec = accept && CMD_I.has_space && !reject;

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      gpib_addr <= GPIB_ADDR_RESET;
    else if (exec && CMD_I.op == OP_GPIB_ADDR)
      gpib_addr <= CMD_I.arg0[4:0];
    else if (WR_I && ADDR_I == REG_GPIB && WDATA_I[4:0] <= GPIB_ADDR_MAX)
      gpib_addr <= WDATA_I[4:0];
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      baud_div <= 16'(BAUD_DIV_DEFAULT);
    else if (exec && CMD_I.op == OP_BAUD)
      baud_div <= CMD_I.arg0;
    else if (WR_I && ADDR_I == REG_BAUD && WDATA_I[15:0] != 16'h0000)
      baud_div <= WDATA_I[15:0];
  end

  // Framing is fixed
  assign BAUD_DIV_O = baud_div;
  assign DATA_BITS_O = DATA_BITS;
  assign PARITY_EN_O = 1'b0;
  assign HW_FLOW_O = 1'b1;

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      amp <= AMP_RESET;
      offs <= OFFS_RESET;
    end
    else if (exec)
    begin
      if (CMD_I.op == OP_AMPLITUDE_SET)
        amp <= CMD_I.arg0;
      if (CMD_I.op == OP_OFFSET_SET)
        offs <= CMD_I.arg0;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      std_shape <= 4'h0;
    else if (exec && CMD_I.op == OP_STD_WAVE_DEFINE)
      std_shape <= CMD_I.arg0[3:0];
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      function_select <= '{ftype: FT_STANDARD_WAVE_TYPE, number: 7'h00, std_shape: 4'h0};
    else if (exec && CMD_I.op == OP_FUNCTION_SELECT)
    begin
      function_select.ftype <= rci_ftype_t'(CMD_I.arg0[1:0]);
      function_select.number <= CMD_I.arg1[6:0];
    end
  end

  // Standard type plays whatever shape was defined last
  always_comb
  begin
    FUNCTION_SELECT_O = function_select;
    FUNCTION_SELECT_O.std_shape = std_shape;
  end

  rci_store u_store
  (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .size_we_i(exec && CMD_I.op == OP_WAVE_SIZE),
    .wave_i(CMD_I.arg0[6:0]),
    .size_i(CMD_I.arg1),
    .seq_del_i(exec && CMD_I.op == OP_SEQ_DEFINE && !CMD_I.has_data),
    .step_we_i(exec && CMD_I.op == OP_SEQUENCE_STEP_ADD),
    .seq_i(CMD_I.arg0[3:0]),
    .step_i(CMD_I.arg3[3:0]),
    .repeat_i(CMD_I.arg2),
    .deleted_o(deleted),
    .wave_present_o(WAVE_PRESENT_O)
  );

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      err_code <= ERR_NONE;
    else if (bad_syntax)
      err_code <= ERR_SPACE;
    else if (reject)
      err_code <= (CMD_I.op == OP_AMPLITUDE_SET || CMD_I.op == OP_OFFSET_SET)
        ? ERR_PEAK : ERR_RANGE;
  end

  always_comb
  begin
    events = '0;
    events[ST_CMD_DONE] = exec;
    events[ST_REJECT] = reject;
    events[ST_BAD_SYNTAX] = bad_syntax;
    events[ST_DELETE] = deleted;
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      status <= '0;
    else if (WR_I && ADDR_I == REG_STATUS)
      status <= (status & ~WDATA_I[ST_WIDTH-1:0]) | events;
    else
      status <= status | events;
  end

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      mask <= '0;
    else if (WR_I && ADDR_I == REG_MASK)
      mask <= WDATA_I[ST_WIDTH-1:0];
  end

  assign IRQ_O = |(status & mask);
  assign AMP_O = amp;
  assign OFFS_O = offs;

  always_ff @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
      RDATA_O <= 32'h0000_0000;
    else if (RD_I)
    begin
      unique case (ADDR_I)
        REG_GPIB: RDATA_O <= 32'(gpib_addr);
        REG_BAUD: RDATA_O <= 32'(baud_div);
        REG_SERIAL: RDATA_O <= 32'(DATA_BITS) | (32'(HW_FLOW_O) << SER_HWFLOW_BIT)
          | (32'(PARITY_EN_O) << SER_PARITY_BIT);
        REG_STATUS: RDATA_O <= 32'(status);
        REG_MASK: RDATA_O <= 32'(mask);
        REG_AMP: RDATA_O <= 32'(amp);
        REG_OFFS: RDATA_O <= 32'(offs);
        REG_FUNCTION_SELECT: RDATA_O <= 32'(FUNCTION_SELECT_O);
        REG_ERRCODE: RDATA_O <= 32'(err_code);
        default: RDATA_O <= 32'h0000_0000;
      endcase
    end
    else
      RDATA_O <= 32'h0000_0000;
  end
endmodule

// ### dv/rci_checker.sv
// Checker: concurrent assertions on the command interpreter top ports.
// Assumes it is bound into rci_top and sees only its ports.
`timescale 1ns/1ns
module rci_checker
  import rci_pkg::*;
(
  input wire logic CLK_I,  // Clock
  input wire logic RESET_I,  // Reset
  input wire logic RD_I,  // Read strobe
  input wire logic WR_I,  // Write strobe
  input wire logic [31:0] RDATA_O,  // Read data
  input wire logic CMD_VALID_I,  // Command strobe
  input wire rci_pkg::rci_cmd_t CMD_I,  // Command
  input wire logic BUS_CMD_I,  // Via bus
  input wire logic LISTEN_O,  // Addressed
  input wire logic [3:0] DATA_BITS_O,  // Data bits
  input wire logic PARITY_EN_O,  // Parity
  input wire logic HW_FLOW_O,  // Flow control
  input wire logic [15:0] AMP_O,  // Amplitude
  input wire logic [15:0] OFFS_O,  // Offset
  input wire rci_pkg::rci_function_select_t FUNCTION_SELECT_O,  // Function
  input wire logic [WAVE_COUNT-1:0] WAVE_PRESENT_O  // Presence
);
  logic [15:0] offs_abs;
  logic [15:0] arg_abs;
  logic taken;
  assign offs_abs = OFFS_O[15] ? 16'h0000 - OFFS_O : OFFS_O;
  assign arg_abs = CMD_I.arg0[15] ? 16'h0000 - CMD_I.arg0 : CMD_I.arg0;
  assign taken = CMD_VALID_I && CMD_I.has_space && (!BUS_CMD_I || LISTEN_O);
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);
  a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 32'h0000_0000)
    else $error("read data not zero outside answer cycle");
  a_fixed_frame: assert property (DATA_BITS_O == DATA_BITS
    && !PARITY_EN_O && HW_FLOW_O)
    else $error("serial framing changed");
  a_peak_limit: assert property (17'(offs_abs) + 17'(AMP_O[15:1]) < 17'(PEAK_LIMIT))
    else $error("active pair exceeds peak limit");
  a_amp_take: assert property (taken && CMD_I.op == OP_AMPLITUDE_SET
    && 17'(offs_abs) + 17'(CMD_I.arg0[15:1]) < 17'(PEAK_LIMIT) |=> AMP_O == $past(CMD_I.arg0))
    else $error("legal amplitude not applied next cycle");
  a_offs_reject: assert property (CMD_VALID_I && CMD_I.op == OP_OFFSET_SET
    && 17'(arg_abs) + 17'(AMP_O[15:1]) >= 17'(PEAK_LIMIT) |=> $stable(OFFS_O))
    else $error("offset over peak limit applied");
  a_nospace_keep: assert property (CMD_VALID_I && !CMD_I.has_space
    |=> $stable(AMP_O) && $stable(OFFS_O) && $stable(FUNCTION_SELECT_O))
    else $error("command without space changed settings");
  a_idle_hold: assert property (!CMD_VALID_I && !WR_I
    |=> $stable(AMP_O) && $stable(FUNCTION_SELECT_O))
    else $error("settings moved without a command");
  a_function_select_take: assert property (taken && CMD_I.op == OP_FUNCTION_SELECT
    && CMD_I.arg0 == 16'h0001 && CMD_I.arg1 < 16'h0064
    |=> FUNCTION_SELECT_O.ftype == FT_USER_WAVE && FUNCTION_SELECT_O.number == $past(CMD_I.arg1[6:0]))
    else $error("user wave selection not applied");
  a_wave_del: assert property (taken && CMD_I.op == OP_WAVE_SIZE
    && CMD_I.arg1 == 16'h0000 && CMD_I.arg0 < 16'h0064
    |=> !WAVE_PRESENT_O[$past(CMD_I.arg0[6:0])])
    else $error("zero size did not remove waveform");
endmodule
bind rci_top rci_checker chk_i(.CLK_I, .RESET_I, .RD_I, .WR_I, .RDATA_O, .CMD_VALID_I,
  .CMD_I, .BUS_CMD_I, .LISTEN_O, .DATA_BITS_O, .PARITY_EN_O, .HW_FLOW_O, .AMP_O,
  .OFFS_O, .FUNCTION_SELECT_O, .WAVE_PRESENT_O);

// ### dv/rci_host.sv
// Host model: sends parsed commands over the command port.
// Assumes one send at a time, called after reset release.
`timescale 1ns/1ns
module rci_host
  import rci_pkg::*;
(
  input wire logic clk_i,  // Clock
  output logic valid_o,  // Command strobe
  output rci_pkg::rci_cmd_t cmd_o,  // Command
  output logic [4:0] bus_addr_o,  // Bus address
  output logic bus_o  // Via bus
);
  initial
  begin
    valid_o = 1'b0;
    cmd_o = '0;
    bus_addr_o = 5'h10;
    bus_o = 1'b0;
  end
  task automatic send(input rci_cmd_t c, input logic bus);
    @(posedge clk_i);
    valid_o <= 1'b1;
    cmd_o <= c;
    bus_o <= bus;
    @(posedge clk_i);
    valid_o <= 1'b0;
    cmd_o <= ~c;
    bus_o <= ~bus;
  endtask
  // Address unique on the bus, matched by rci_top
  task automatic addr(input logic [4:0] a);
    @(posedge clk_i);
    bus_addr_o <= a;
  endtask
endmodule

// ### dv/rci_top_tb.sv
// Testbench: register and command sequences with expected values.
// Assumes rci_host as the command source and the bound checker.
`timescale 1ns/1ns
module rci_top_tb;
  import rci_pkg::*;
  logic CLK_I = 1'b0;
  logic RESET_I, WR_I, RD_I, CMD_VALID_I, BUS_CMD_I, LISTEN_O, PARITY_EN_O, HW_FLOW_O, IRQ_O;
  logic [7:0] ADDR_I;
  logic [31:0] WDATA_I, RDATA_O;
  logic [4:0] BUS_ADDR_I;
  logic [15:0] BAUD_DIV_O, AMP_O, OFFS_O;
  logic [3:0] DATA_BITS_O;
  logic [WAVE_COUNT-1:0] WAVE_PRESENT_O;
  rci_cmd_t CMD_I, c;
  rci_function_select_t FUNCTION_SELECT_O;
  int n_errors = 0;
  int checks = 0;
  always #20 CLK_I = ~CLK_I;
  rci_top dut(.CLK_I, .RESET_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .CMD_VALID_I,
    .CMD_I, .BUS_ADDR_I, .BUS_CMD_I, .LISTEN_O, .BAUD_DIV_O, .DATA_BITS_O, .PARITY_EN_O,
    .HW_FLOW_O, .AMP_O, .OFFS_O, .FUNCTION_SELECT_O, .WAVE_PRESENT_O, .IRQ_O);
  rci_host h(.clk_i(CLK_I), .valid_o(CMD_VALID_I), .cmd_o(CMD_I), .bus_addr_o(BUS_ADDR_I),
    .bus_o(BUS_CMD_I));
  task automatic end_sim;
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CLK_I);
    WR_I <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    @(negedge CLK_I);
    chk(RDATA_O, e);
  endtask
  function automatic rci_cmd_t mk(input rci_op_t op, input logic [15:0] a0,
    input logic [15:0] a1 = 16'h0000, a2 = 16'h0000, a3 = 16'h0000);
    mk = '{op, 1'b1, 1'b0, a0, a1, a2, a3};
  endfunction
  task automatic cmd(input rci_cmd_t x);
    h.send(x, 1'b0);
    @(negedge CLK_I);
  endtask
  // Delete flag lands one cycle after the command
  task automatic del_irq;
    @(negedge CLK_I);
    chk(IRQ_O, 1'b1);
    wr(REG_STATUS, 32'h0000_0008);
  endtask
  initial
  begin
    #200000;
    n_errors++;
    end_sim;
  end
  initial
  begin
    RESET_I = 1'b1;
    WR_I = 1'b0;
    RD_I = 1'b0;
    ADDR_I = 8'h00;
    WDATA_I = 32'h0000_0000;
    repeat (16) @(posedge CLK_I);
    RESET_I <= 1'b0;
    rd(REG_GPIB, 32'h0000_0010);
    rd(REG_BAUD, 32'h0000_0516);
    chk(BAUD_DIV_O, 32'(BAUD_DIV_DEFAULT));
    rd(REG_SERIAL, 32'h0000_0028);
    wr(REG_SERIAL, 32'h0000_0000);
    rd(REG_SERIAL, 32'h0000_0028);
    wr(REG_BAUD, 32'h0000_0100);
    @(negedge CLK_I);
    chk(BAUD_DIV_O, 32'h0000_0100);
    wr(REG_GPIB, 32'h0000_001F);
    rd(REG_GPIB, 32'h0000_0010);
    wr(REG_GPIB, 32'h0000_001E);
    h.addr(5'h1E);
    @(negedge CLK_I);
    chk(LISTEN_O, 1'b1);
    h.addr(5'h1D);
    h.send(mk(OP_AMPLITUDE_SET, 16'h03E8), 1'b1);
    @(negedge CLK_I);
    chk(AMP_O, 32'h0000_0000);
    chk(LISTEN_O, 1'b0);
    h.addr(5'h1E);
    h.send(mk(OP_AMPLITUDE_SET, 16'h03E8), 1'b1);
    @(negedge CLK_I);
    chk(AMP_O, 32'h0000_03E8);
    rd(8'h3C, 32'h0000_0000);
    wr(REG_STATUS, 32'h0000_000F);
    wr(REG_MASK, 32'h0000_0002);
    cmd(mk(OP_AMPLITUDE_SET, 16'h2710));
    chk(AMP_O, 32'h0000_2710);
    chk(IRQ_O, 1'b0);
    cmd(mk(OP_OFFSET_SET, 16'h1D4C));
    chk(OFFS_O, 32'h0000_0000);
    rd(REG_ERRCODE, 32'h0000_0001);
    chk(IRQ_O, 1'b1);
    wr(REG_STATUS, 32'h0000_0002);
    @(negedge CLK_I);
    chk(IRQ_O, 1'b0);
    cmd(mk(OP_AMPLITUDE_SET, 16'h03E8));
    cmd(mk(OP_OFFSET_SET, 16'h1D4C));
    chk(OFFS_O, 32'h0000_1D4C);
    cmd(mk(OP_OFFSET_SET, 16'h26AC));
    chk(OFFS_O, 32'h0000_1D4C);
    cmd(mk(OP_OFFSET_SET, 16'hD955));
    chk(OFFS_O, 32'h0000_D955);
    c = mk(OP_AMPLITUDE_SET, 16'h0064);
    c.has_space = 1'b0;
    cmd(c);
    chk(AMP_O, 32'h0000_03E8);
    rd(REG_ERRCODE, 32'h0000_0002);
    cmd(mk(OP_GPIB_ADDR, 16'h001F));
    rd(REG_ERRCODE, 32'h0000_0003);
    rd(REG_GPIB, 32'h0000_001E);
    cmd(mk(OP_BAUD, 16'h0200));
    chk(BAUD_DIV_O, 32'h0000_0200);
    cmd(mk(OP_STD_WAVE_DEFINE, 16'h0005));
    cmd(mk(OP_FUNCTION_SELECT, 16'h0000));
    chk(FUNCTION_SELECT_O, {2'h0, 7'h00, 4'h5});
    cmd(mk(OP_FUNCTION_SELECT, 16'h0001, 16'h000C));
    chk(FUNCTION_SELECT_O, {2'h1, 7'h0C, 4'h5});
    cmd(mk(OP_FUNCTION_SELECT, 16'h0002, 16'h0009));
    chk(FUNCTION_SELECT_O, {2'h2, 7'h09, 4'h5});
    wr(REG_STATUS, 32'h0000_000F);
    wr(REG_MASK, 32'h0000_0008);
    cmd(mk(OP_WAVE_SIZE, 16'h000A, 16'h0064));
    chk(WAVE_PRESENT_O[10], 1'b1);
    cmd(mk(OP_WAVE_SIZE, 16'h000A, 16'h0000));
    chk(WAVE_PRESENT_O[10], 1'b0);
    del_irq;
    cmd(mk(OP_WAVE_SIZE, 16'h000A, 16'h0064));
    cmd(mk(OP_SEQUENCE_STEP_ADD, 16'h0001, 16'h000A, 16'h0005, 16'h0003));
    @(negedge CLK_I);
    chk(IRQ_O, 1'b0);
    cmd(mk(OP_SEQUENCE_STEP_ADD, 16'h0001, 16'h000A, 16'h0000, 16'h0003));
    del_irq;
    cmd(mk(OP_SEQUENCE_STEP_ADD, 16'h0001, 16'h000A, 16'h0002, 16'h0004));
    cmd(mk(OP_SEQ_DEFINE, 16'h0001));
    del_irq;
    end_sim;
  end
endmodule
